// ==== rtl/ebtp_pin_sync.v ====
`timescale 1ns/100ps
`default_nettype none

module ebtp_pin_sync (
	input  wire ref_clk,
	input  wire reset,
	input  wire pin,
	output reg  rise,
	output reg  fall
);

	reg s1;
	reg s2;
	reg s3;
	reg filt;
	wire agree = (s2 == s3);

	// A change counts only once the second and third stages agree
	always @(posedge ref_clk) begin
		if (reset) begin
			s1 <= 1'h0;
			s2 <= 1'h0;
			s3 <= 1'h0;
			filt <= 1'h0;
			rise <= 1'h0;
			fall <= 1'h0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (agree)
				filt <= s2;
			rise <= agree & s2 & ~filt;
			fall <= agree & ~s2 & filt;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/ebtp_regs.vh ====
`ifndef EBTP_REGS_VH
`define EBTP_REGS_VH

// Byte offsets inside one channel pair, even byte = channel 0
`define EBTP_OFS_CTRL     4'h0
`define EBTP_OFS_STAT     4'h2
`define EBTP_OFS_CORA     4'h4
`define EBTP_OFS_CORB     4'h6
`define EBTP_OFS_CNT      4'h8

`define EBTP_RST_CNT      8'h00
`define EBTP_RST_CTRL     8'h00
`define EBTP_RST_COR      8'hFF
`define EBTP_RST_STAT     8'h00
`define EBTP_CNT_MAX      8'hFF

// channel_control fields
`define EBTP_CTRL_IEB     7
`define EBTP_CTRL_IEA     6
`define EBTP_CTRL_IEW     5
`define EBTP_CTRL_CLR_HI  4
`define EBTP_CTRL_CLR_LO  3
`define EBTP_CTRL_CKS_HI  2
`define EBTP_CTRL_CKS_LO  0

// channel_status_control fields
`define EBTP_STAT_FB      7
`define EBTP_STAT_FA      6
`define EBTP_STAT_FW      5
`define EBTP_STAT_ICE     4
`define EBTP_STAT_OSB_HI  3
`define EBTP_STAT_OSB_LO  2
`define EBTP_STAT_OSA_HI  1
`define EBTP_STAT_OSA_LO  0

// Clock select codes
`define EBTP_CKS_STOP     3'h0
`define EBTP_CKS_DIV8     3'h1
`define EBTP_CKS_DIV64    3'h2
`define EBTP_CKS_DIV8K    3'h3
`define EBTP_CKS_CASC     3'h4

// Clear select codes
`define EBTP_CLR_NONE     2'h0
`define EBTP_CLR_MA       2'h1
`define EBTP_CLR_MB       2'h2
`define EBTP_CLR_CAP      2'h3

// Edge codes, low two bits of external clock codes and capture edge
`define EBTP_EDGE_RISE    2'h1
`define EBTP_EDGE_FALL    2'h2
`define EBTP_EDGE_BOTH    2'h3

// Output actions on a match event
`define EBTP_OUT_LOW      2'h1
`define EBTP_OUT_HIGH     2'h2
`define EBTP_OUT_TOG      2'h3

// Prescaler: terminal counts for system clock / 8, / 64, / 8192
`define EBTP_PRE_W        13
`define EBTP_DIV8_MASK    13'h0007
`define EBTP_DIV64_MASK   13'h003F
`define EBTP_DIV8K_MASK   13'h1FFF

`endif

// ==== rtl/ebtp_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "ebtp_regs.vh"
// Operation
// - 8-bit counter counts selected clock pulses
// - CPU reads or overwrites counter any time
// - Pair registers accessible as one word
// - Even channel upper byte, odd lower
// - Wrap from max to zero sets flag
// - Reset/standby: counter, control zero, compares ones
// - Equality with constant A sets flag A
// - Match A drives output per select bits
// - Equality with register B sets flag B
// - Match B drives output per bits 3:2
// - Capture edge latches counter, sets flag B
// - Odd capture mode blocks even flag B
// - Control bit 7 gates flag B request
// - Control bit 6 gates flag A request
// - Control bit 5 gates wrap request
// - Clear select chooses counter clear source
// - Odd capture-clear stops even B clear
// - Codes 0-3: stop, divide 8/64/8192
// - Codes 5-7: pin rise, fall, both
// - Code 4 cascades overflow or match A

module ebtp_top (
	input  wire        ref_clk,
	input  wire        reset,
	input  wire        standby,
	input  wire [3:0]  cpu_addr,
	input  wire        cpu_rd,
	input  wire        cpu_wr,
	input  wire        cpu_word,
	input  wire [15:0] cpu_wdata,
	output reg  [15:0] cpu_rdata,
	input  wire        clk_pin_0,
	input  wire        clk_pin_1,
	input  wire        tmio_1_in,
	output wire        tmo_0,
	output wire        tmio_1_out,
	output reg         tmio_1_oe,
	output wire [1:0]  match_a_irq,
	output wire [1:0]  match_b_irq,
	output wire [1:0]  wrap_irq
);

	function edge_pick;
		input [1:0] sel;
		input       r;
		input       f;
		begin
			case (sel)
			`EBTP_EDGE_RISE: edge_pick = r;
			`EBTP_EDGE_FALL: edge_pick = f;
			`EBTP_EDGE_BOTH: edge_pick = r | f;
			default:         edge_pick = 1'h0;
			endcase
		end
	endfunction

	function clk_pick;
		input [2:0] cks;
		input       t8;
		input       t64;
		input       t8k;
		input       casc;
		input       r;
		input       f;
		begin
			case (cks)
			`EBTP_CKS_STOP:  clk_pick = 1'h0;
			`EBTP_CKS_DIV8:  clk_pick = t8;
			`EBTP_CKS_DIV64: clk_pick = t64;
			`EBTP_CKS_DIV8K: clk_pick = t8k;
			`EBTP_CKS_CASC:  clk_pick = casc;
			default:         clk_pick = edge_pick(cks[1:0], r, f);
			endcase
		end
	endfunction

	function out_act;
		input [1:0] sel;
		input       lvl;
		input       ev;
		begin
			if (!ev)
				out_act = lvl;
			else begin
				case (sel)
				`EBTP_OUT_LOW:  out_act = 1'h0;
				`EBTP_OUT_HIGH: out_act = 1'h1;
				`EBTP_OUT_TOG:  out_act = ~lvl;
				default:        out_act = lvl;
				endcase
			end
		end
	endfunction

	function [7:0] reg_pick;
		input [3:0] base;
		input [7:0] ctrl;
		input [7:0] stat;
		input [7:0] cora;
		input [7:0] corb;
		input [7:0] cnt;
		begin
			case (base)
			`EBTP_OFS_CTRL: reg_pick = ctrl;
			`EBTP_OFS_STAT: reg_pick = stat;
			`EBTP_OFS_CORA: reg_pick = cora;
			`EBTP_OFS_CORB: reg_pick = corb;
			`EBTP_OFS_CNT:  reg_pick = cnt;
			default:        reg_pick = 8'h00;
			endcase
		end
	endfunction

	// Standby holds the block exactly as reset does
	wire rst = reset | standby;

	reg  [`EBTP_PRE_W-1:0] presc;
	wire                   t8;
	wire                   t64;
	wire                   t8k;
	wire [2:0]             pins;
	wire [2:0]             prise;
	wire [2:0]             pfall;
	wire [3:0]             base;
	wire [15:0]            cnt_v;
	wire [15:0]            stat_v;
	wire [15:0]            ctrl_v;
	wire [15:0]            rd_v;
	wire [1:0]             mta_v;
	wire [1:0]             wrap_v;
	wire [1:0]             tmo_v;
	wire                   ice1;
	wire                   cap_edge;

	always @(posedge ref_clk) begin
		if (rst)
			presc <= {`EBTP_PRE_W{1'h0}};
		else
			presc <= presc + 1'h1;
	end

	// Ticks sit on the cycle before the divided phase falls
	assign t8  = (presc & `EBTP_DIV8_MASK) == `EBTP_DIV8_MASK;
	assign t64 = (presc & `EBTP_DIV64_MASK) == `EBTP_DIV64_MASK;
	assign t8k = presc == `EBTP_DIV8K_MASK;

	assign pins = {tmio_1_in, clk_pin_1, clk_pin_0};

	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_pin
			ebtp_pin_sync u_sync (
				.ref_clk (ref_clk),
				.reset   (rst),
				.pin     (pins[k]),
				.rise    (prise[k]),
				.fall    (pfall[k])
			);
		end
	endgenerate

	assign base = {cpu_addr[3:1], 1'h0};
	assign ice1 = stat_v[8 + `EBTP_STAT_ICE];
	// Capture edge is picked by the odd channel's bits 3:2
	assign cap_edge = ice1 & edge_pick(
		stat_v[8 + `EBTP_STAT_OSB_HI:8 + `EBTP_STAT_OSB_LO],
		prise[2], pfall[2]);

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_ch
			localparam [0:0] ODD = (i == 1) ? 1'h1 : 1'h0;
			reg  [7:0] cnt;
			reg  [7:0] cora;
			reg  [7:0] corb;
			reg  [7:0] ctrl;
			reg  [7:0] stat;
			reg  [2:0] arm;
			reg        eqa_q;
			reg        eqb_q;
			reg        tmo;
			reg        irq_a;
			reg        irq_b;
			reg        irq_w;
			wire       acc;
			wire [7:0] wd;
			wire       wr_ctrl;
			wire       wr_stat;
			wire       wr_cora;
			wire       wr_corb;
			wire       wr_cnt;
			wire       casc;
			wire       tick;
			wire       eqa;
			wire       eqb;
			wire       mta;
			wire       mtb_raw;
			wire       mtb;
			wire       capv;
			wire       b_ev;
			wire       clr;
			wire       wrap;
			wire [2:0] flag_set;
			wire [2:0] flag_clr;
			wire       out_a;
			reg        clr_sel_hit;

			assign acc = cpu_word | (cpu_addr[0] == ODD);
			assign wd = (cpu_word && !ODD) ?
				cpu_wdata[15:8] : cpu_wdata[7:0];
			assign wr_ctrl = cpu_wr & acc & (base == `EBTP_OFS_CTRL);
			assign wr_stat = cpu_wr & acc & (base == `EBTP_OFS_STAT);
			assign wr_cora = cpu_wr & acc & (base == `EBTP_OFS_CORA);
			assign wr_corb = cpu_wr & acc & (base == `EBTP_OFS_CORB);
			assign wr_cnt  = cpu_wr & acc & (base == `EBTP_OFS_CNT);

			// Even side counts partner wraps, odd side partner match A
			assign casc = ODD ? mta_v[0] : wrap_v[1];
			assign tick = clk_pick(
				ctrl[`EBTP_CTRL_CKS_HI:`EBTP_CTRL_CKS_LO],
				t8, t64, t8k, casc, prise[i], pfall[i]);

			// Edge of equality, so a held match fires only once
			assign eqa = (cnt == cora);
			assign eqb = (cnt == corb);
			assign mta = eqa & ~eqa_q;
			assign mtb_raw = eqb & ~eqb_q & ~(ODD & ice1);
			assign mtb = mtb_raw & ~(~ODD & ice1);
			assign capv = ODD & cap_edge;
			assign b_ev = mtb | capv;

			always @* begin
				case (ctrl[`EBTP_CTRL_CLR_HI:`EBTP_CTRL_CLR_LO])
				`EBTP_CLR_MA: clr_sel_hit = mta;
				`EBTP_CLR_MB: clr_sel_hit = ODD ? b_ev :
					mtb_raw & (ctrl_v[8 + `EBTP_CTRL_CLR_HI:
					8 + `EBTP_CTRL_CLR_LO] != `EBTP_CLR_CAP);
				`EBTP_CLR_CAP: clr_sel_hit = cap_edge;
				default: clr_sel_hit = 1'h0;
				endcase
			end

			assign clr = clr_sel_hit;
			assign wrap = tick & (cnt == `EBTP_CNT_MAX) & ~wr_cnt & ~clr;
			assign flag_set = {b_ev, mta, wrap};
			assign flag_clr = arm & ~wd[`EBTP_STAT_FB:`EBTP_STAT_FW] &
				{3{wr_stat}};
			assign out_a = out_act(
				stat[`EBTP_STAT_OSA_HI:`EBTP_STAT_OSA_LO], tmo, mta);

			always @(posedge ref_clk) begin
				if (rst) begin
					cnt <= `EBTP_RST_CNT;
					cora <= `EBTP_RST_COR;
					corb <= `EBTP_RST_COR;
					ctrl <= `EBTP_RST_CTRL;
					stat <= `EBTP_RST_STAT;
					arm <= 3'h0;
					eqa_q <= 1'h0;
					eqb_q <= 1'h0;
					tmo <= 1'h0;
					irq_a <= 1'h0;
					irq_b <= 1'h0;
					irq_w <= 1'h0;
				end else begin
					eqa_q <= eqa;
					eqb_q <= eqb;
					// CPU write beats a clear, a clear beats a count
					if (wr_cnt)
						cnt <= wd;
					else if (clr)
						cnt <= 8'h00;
					else if (tick)
						cnt <= cnt + 8'h01;
					if (wr_ctrl)
						ctrl <= wd;
					if (wr_cora)
						cora <= wd;
					// Capture outranks a CPU write in the same cycle
					if (capv)
						corb <= cnt;
					else if (wr_corb)
						corb <= wd;
					// A flag event in the clearing cycle keeps the flag
					stat[`EBTP_STAT_FB:`EBTP_STAT_FW] <= flag_set |
						(stat[`EBTP_STAT_FB:`EBTP_STAT_FW] &
						~flag_clr);
					if (wr_stat)
						stat[`EBTP_STAT_ICE:0] <= wd[`EBTP_STAT_ICE:0];
					if (wr_stat)
						arm <= 3'h0;
					else if (cpu_rd && acc && base == `EBTP_OFS_STAT)
						arm <= arm | stat[`EBTP_STAT_FB:`EBTP_STAT_FW];
					if (!(ODD && ice1))
						tmo <= out_act(
							stat[`EBTP_STAT_OSB_HI:`EBTP_STAT_OSB_LO],
							out_a, mtb);
					irq_b <= stat[`EBTP_STAT_FB] &
						ctrl[`EBTP_CTRL_IEB];
					irq_a <= stat[`EBTP_STAT_FA] &
						ctrl[`EBTP_CTRL_IEA];
					irq_w <= stat[`EBTP_STAT_FW] &
						ctrl[`EBTP_CTRL_IEW];
				end
			end

			assign cnt_v[i*8 +: 8] = cnt;
			assign stat_v[i*8 +: 8] = stat;
			assign ctrl_v[i*8 +: 8] = ctrl;
			assign rd_v[i*8 +: 8] = reg_pick(base, ctrl, stat, cora,
				corb, cnt);
			assign mta_v[i] = mta;
			assign wrap_v[i] = wrap;
			assign tmo_v[i] = tmo;
			assign match_a_irq[i] = irq_a;
			assign match_b_irq[i] = irq_b;
			assign wrap_irq[i] = irq_w;
		end
	endgenerate

	assign tmo_0 = tmo_v[0];
	assign tmio_1_out = tmo_v[1];

	// Word reads sample both bytes in one cycle, so no torn counts
	always @(posedge ref_clk) begin
		if (rst) begin
			cpu_rdata <= 16'h0000;
			tmio_1_oe <= 1'h0;
		end else begin
			tmio_1_oe <= ~ice1;
			if (cpu_rd) begin
				if (cpu_word)
					cpu_rdata <= {rd_v[7:0], rd_v[15:8]};
				else if (cpu_addr[0])
					cpu_rdata <= {8'h00, rd_v[15:8]};
				else
					cpu_rdata <= {8'h00, rd_v[7:0]};
			end
		end
	end

endmodule

`default_nettype wire

// ==== sim/ebtp_top_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebtp_top_sva (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        standby,
	input wire logic [3:0]  cpu_addr,
	input wire logic        cpu_rd,
	input wire logic        cpu_wr,
	input wire logic        cpu_word,
	input wire logic [15:0] cpu_wdata,
	input wire logic [15:0] cpu_rdata,
	input wire logic        tmio_1_out,
	input wire logic        tmio_1_oe,
	input wire logic [1:0]  match_a_irq,
	input wire logic [1:0]  match_b_irq,
	input wire logic [1:0]  wrap_irq
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset || standby);
	wire ctrl_w = cpu_wr && cpu_word && cpu_addr[3:1] == 3'h0;
	a_reset_clears: assert property ($fell(reset || standby) |->
		cpu_rdata == 16'h0000 && !tmio_1_oe && wrap_irq == 2'h0)
		else $error("outputs not cleared by reset");
	a_rdata_holds: assert property (!cpu_rd |=> $stable(cpu_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (cpu_rd && cpu_addr > 4'h9
		|=> cpu_rdata == 16'h0000)
		else $error("unmapped offset read nonzero");
	a_byte_upper: assert property (cpu_rd && !cpu_word
		|=> cpu_rdata[15:8] == 8'h00)
		else $error("byte read upper half nonzero");
	a_irq_b_gate: assert property (ctrl_w && !cpu_wdata[15]
		&& !cpu_wdata[7] |-> ##2 match_b_irq == 2'h0)
		else $error("match b request while disabled");
	a_irq_a_gate: assert property (ctrl_w && !cpu_wdata[14]
		&& !cpu_wdata[6] |-> ##2 match_a_irq == 2'h0)
		else $error("match a request while disabled");
	a_wrap_gate: assert property (ctrl_w && !cpu_wdata[13]
		&& !cpu_wdata[5] |-> ##2 wrap_irq == 2'h0)
		else $error("wrap request while disabled");
	a_capture_holds: assert property (!tmio_1_oe ##1 !tmio_1_oe
		|-> $stable(tmio_1_out))
		else $error("output moved in capture mode");
endmodule
bind ebtp_top ebtp_top_sva i_ebtp_top_sva (.*);
`default_nettype wire

// ==== sim/ebtp_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebtp_top_test;
	logic        ref_clk;
	logic        reset;
	logic        standby;
	logic [3:0]  cpu_addr;
	logic        cpu_rd;
	logic        cpu_wr;
	logic        cpu_word;
	logic [15:0] cpu_wdata;
	logic [2:0]  pins;
	wire  [15:0] cpu_rdata;
	wire         tmo_0;
	wire         tmio_1_out;
	wire         tmio_1_oe;
	wire  [1:0]  match_a_irq;
	wire  [1:0]  match_b_irq;
	wire  [1:0]  wrap_irq;
	int          err_total;
	int          n_tests;
	ebtp_top i_ebtp_top (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.standby     (standby),
		.cpu_addr    (cpu_addr),
		.cpu_rd      (cpu_rd),
		.cpu_wr      (cpu_wr),
		.cpu_word    (cpu_word),
		.cpu_wdata   (cpu_wdata),
		.cpu_rdata   (cpu_rdata),
		.clk_pin_0   (pins[0]),
		.clk_pin_1   (pins[1]),
		.tmio_1_in   (pins[2]),
		.tmo_0       (tmo_0),
		.tmio_1_out  (tmio_1_out),
		.tmio_1_oe   (tmio_1_oe),
		.match_a_irq (match_a_irq),
		.match_b_irq (match_b_irq),
		.wrap_irq    (wrap_irq)
	);
	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One idle cycle follows each access, so strobes never merge
	task acc(input logic r, input logic [3:0] a, input logic w,
		input logic [15:0] d);
		@(posedge ref_clk);
		cpu_rd <= r;
		cpu_wr <= !r;
		cpu_addr <= a;
		cpu_word <= w;
		cpu_wdata <= d;
		@(posedge ref_clk);
		cpu_rd <= 1'h0;
		cpu_wr <= 1'h0;
		#1;
	endtask
	task rchk(input logic [3:0] a, input logic w, input logic [15:0] e);
		acc(1'h1, a, w, 16'h0000);
		chk(cpu_rdata, e);
	endtask
	// Four cycles per level keeps the pin past the input filter
	task tog(input int k);
		repeat (4) @(posedge ref_clk);
		pins[k] <= !pins[k];
	endtask
	task t_reset;
		rchk(4'h0, 1'h1, 16'h0000);
		rchk(4'h4, 1'h1, 16'hFFFF);
		rchk(4'h6, 1'h1, 16'hFFFF);
		rchk(4'hA, 1'h1, 16'h0000);
		rchk(4'h8, 1'h1, 16'h0000);
	endtask
	task t_word;
		acc(1'h0, 4'h8, 1'h1, 16'h1234);
		rchk(4'h8, 1'h1, 16'h1234);
		rchk(4'h8, 1'h0, 16'h0012);
		rchk(4'h9, 1'h0, 16'h0034);
		acc(1'h0, 4'h9, 1'h0, 16'h0056);
		rchk(4'h8, 1'h1, 16'h1256);
	endtask
	task t_presc;
		int d;
		for (int c = 0; c < 4; c++) begin
			d = (c == 3) ? 8192 : (c == 2) ? 64 : 8;
			acc(1'h0, 4'h1, 1'h0, 16'(c));
			acc(1'h0, 4'h9, 1'h0, 16'h0000);
			repeat (2 * d - 1) @(posedge ref_clk);
			rchk(4'h9, 1'h0, 16'((c == 0) ? 0 : 2));
		end
		acc(1'h0, 4'h1, 1'h0, 16'h0000);
	endtask
	task t_ext;
		for (int c = 5; c < 8; c++) begin
			acc(1'h0, 4'h0, 1'h0, 16'(c));
			acc(1'h0, 4'h8, 1'h0, 16'h0000);
			repeat (6) tog(0);
			repeat (6) @(posedge ref_clk);
			rchk(4'h8, 1'h0, 16'((c == 7) ? 6 : 3));
		end
	endtask
	task t_match;
		int i;
		acc(1'h0, 4'h4, 1'h0, 16'h0003);
		// The pin test leaves the counter past A, so restart it at zero
		acc(1'h0, 4'h8, 1'h0, 16'h0000);
		acc(1'h0, 4'h0, 1'h0, 16'h0049);
		for (i = 0; i < 100 && match_a_irq[0] !== 1'h1; i++)
			@(posedge ref_clk) #1;
		chk({15'h0, match_a_irq[0]}, 16'h0001);
		acc(1'h0, 4'h0, 1'h0, 16'h0040);
		rchk(4'h8, 1'h0, 16'h0000);
		acc(1'h0, 4'h2, 1'h0, 16'h0000);
		rchk(4'h2, 1'h0, 16'h0040);
		acc(1'h0, 4'h2, 1'h0, 16'h0000);
		acc(1'h0, 4'h2, 1'h0, 16'h00E0);
		rchk(4'h2, 1'h0, 16'h0000);
		chk({14'h0, match_a_irq}, 16'h0000);
	endtask
	task t_casc;
		acc(1'h0, 4'h0, 1'h1, 16'h0421);
		acc(1'h0, 4'h3, 1'h0, 16'h0002);
		acc(1'h0, 4'h8, 1'h1, 16'h00FE);
		repeat (15) @(posedge ref_clk);
		rchk(4'h8, 1'h1, 16'h0100);
		chk({14'h0, wrap_irq}, 16'h0002);
		// Passing FF also equals both compare registers at reset value
		rchk(4'h3, 1'h0, 16'h00E2);
		chk({15'h0, tmio_1_out}, 16'h0001);
		acc(1'h0, 4'h0, 1'h1, 16'h0000);
	endtask
	task t_capt;
		acc(1'h0, 4'h3, 1'h0, 16'h0014);
		acc(1'h0, 4'h1, 1'h0, 16'h0098);
		acc(1'h0, 4'h9, 1'h0, 16'h005A);
		acc(1'h0, 4'h0, 1'h0, 16'h0010);
		acc(1'h0, 4'h6, 1'h0, 16'h0033);
		acc(1'h0, 4'h8, 1'h0, 16'h0033);
		tog(2);
		repeat (6) @(posedge ref_clk);
		rchk(4'h6, 1'h1, 16'h335A);
		rchk(4'h8, 1'h1, 16'h3300);
		rchk(4'h2, 1'h0, 16'h0000);
		rchk(4'h3, 1'h0, 16'h0094);
		chk({15'h0, tmio_1_oe}, 16'h0000);
		chk({14'h0, match_b_irq}, 16'h0002);
		tog(2);
		acc(1'h0, 4'h3, 1'h0, 16'h0000);
	endtask
	task t_out;
		acc(1'h0, 4'h2, 1'h0, 16'h0006);
		acc(1'h0, 4'h4, 1'h1, 16'h40FF);
		acc(1'h0, 4'h6, 1'h1, 16'h80FF);
		acc(1'h0, 4'h8, 1'h0, 16'h0040);
		repeat (2) @(posedge ref_clk);
		chk({15'h0, tmo_0}, 16'h0001);
		acc(1'h0, 4'h8, 1'h0, 16'h0080);
		repeat (2) @(posedge ref_clk);
		chk({15'h0, tmo_0}, 16'h0000);
	endtask
	task t_stby;
		@(posedge ref_clk);
		standby <= 1'h1;
		@(posedge ref_clk);
		standby <= 1'h0;
		rchk(4'h4, 1'h1, 16'hFFFF);
		rchk(4'h0, 1'h1, 16'h0000);
		rchk(4'h2, 1'h0, 16'h0000);
		chk({15'h0, tmio_1_out}, 16'h0000);
	endtask
	initial begin
		reset = 1'h1;
		standby = 1'h0;
		cpu_addr = 4'h0;
		cpu_rd = 1'h0;
		cpu_wr = 1'h0;
		cpu_word = 1'h0;
		cpu_wdata = 16'h0000;
		pins = 3'h0;
		err_total = 0;
		n_tests = 0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'h0;
		t_reset;
		t_word;
		t_presc;
		t_ext;
		t_match;
		t_casc;
		t_capt;
		t_out;
		t_stby;
		give_verdict;
	end
	// The slowest divider dominates the run; this leaves ample margin
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		give_verdict;
	end
endmodule
`default_nettype wire
